// ### sar_adc_conversion_control.sv
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "sar_adc_regs.svh"
module sar_adc_conversion_control
  import sar_adc_pkg::*;
(
  input wire logic ref_clk,                 // System clock, 10 MHz
  input wire logic rst_n,                   // Asynchronous reset, active low
  input wire logic [11:0] s_axi_awaddr,     // Write address
  input wire logic s_axi_awvalid,           // Write address valid
  output logic s_axi_awready,               // Write address ready
  input wire logic [31:0] s_axi_wdata,      // Write data
  input wire logic [3:0] s_axi_wstrb,       // Write byte strobes
  input wire logic s_axi_wvalid,            // Write data valid
  output logic s_axi_wready,                // Write data ready
  output logic [1:0] s_axi_bresp,           // Write response
  output logic s_axi_bvalid,                // Write response valid
  input wire logic s_axi_bready,            // Write response ready
  input wire logic [11:0] s_axi_araddr,     // Read address
  input wire logic s_axi_arvalid,           // Read address valid
  output logic s_axi_arready,               // Read address ready
  output logic [31:0] s_axi_rdata,          // Read data
  output logic [1:0] s_axi_rresp,           // Read response
  output logic s_axi_rvalid,                // Read data valid
  input wire logic s_axi_rready,            // Read data ready
  input wire timer_strobe_type timerOvf,    // Timer overflow strobes, same clock
  input wire logic convertStartPin,         // External convert start pin
  input wire logic [11:0] sarCode,          // Code from the SAR array at conversion end
  output analog_ctl_type analogCtl,         // Controls to the analog converter
  output logic irq                          // Level interrupt
);

  // =========================================
  // Reset release and pin synchroniser
  logic rstMeta;
  logic rstn;
  logic pinMeta;
  logic pinSync;
  logic pinPrev;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstn <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstn <= rstMeta;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pinMeta <= 1'b0;
      pinSync <= 1'b0;
      pinPrev <= 1'b0;
    end else begin
      pinMeta <= convertStartPin;
      pinSync <= pinMeta;
      pinPrev <= pinSync;
    end
  end

  // =========================================
  // Functions
  function automatic logic [8:0] regIndex(input logic [11:0] addr);
    regIndex = {(addr[1:0] != 2'b00), addr[9:2]};
  endfunction : regIndex

  function automatic logic [15:0] formatResult(input logic [11:0] code, input logic leftJ,
                                               input logic diff);
    if (leftJ) begin
      formatResult = {code, 4'h0};
    end else if (diff) begin
      formatResult = {{4{code[11]}}, code};
    end else begin
      formatResult = {4'h0, code};
    end
  endfunction : formatResult

  // =========================================
  // Registers
  logic enable;
  logic lowPowerTrack;
  logic doneFlag;
  logic [2:0] startSource;
  logic leftJustify;
  logic [4:0] divisor;
  logic [4:0] posChannel;
  logic [4:0] negChannel;
  logic t2Wide;
  logic t3Wide;
  logic standby;
  logic droppedFlag;
  logic [1:0] irqMask;
  logic [15:0] result;
  conv_state_type state;
  logic [3:0] phaseCount;
  logic [5:0] rateCount;
  logic completePulse;

  // =========================================
  // Write channel
  logic [11:0] awAddr;
  logic awHeld;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic wHeld;

  wire writeFire = awHeld && wHeld && !s_axi_bvalid;
  wire [8:0] wIndex = regIndex(awAddr);
  wire wLane0 = writeFire && wStrb[0];
  wire [7:0] wByte = wData[7:0];
  wire wrControl = wLane0 && (wIndex == {1'b0, `RA_CONTROL});
  wire wrConfig = wLane0 && (wIndex == {1'b0, `RA_CONFIG});
  wire wrPos = wLane0 && (wIndex == {1'b0, `RA_POS_SEL});
  wire wrNeg = wLane0 && (wIndex == {1'b0, `RA_NEG_SEL});
  wire wrStatus = wLane0 && (wIndex == {1'b0, `RA_IRQ_STATUS});
  wire wrMask = wLane0 && (wIndex == {1'b0, `RA_IRQ_MASK});
  wire wrTimerMode = wLane0 && (wIndex == {1'b0, `RA_TIMER_MODE});
  wire wMapped = (wIndex == {1'b0, `RA_CONTROL}) || (wIndex == {1'b0, `RA_CONFIG}) ||
                 (wIndex == {1'b0, `RA_POS_SEL}) || (wIndex == {1'b0, `RA_NEG_SEL}) ||
                 (wIndex == {1'b0, `RA_IRQ_STATUS}) || (wIndex == {1'b0, `RA_IRQ_MASK}) ||
                 (wIndex == {1'b0, `RA_TIMER_MODE}) || (wIndex == {1'b0, `RA_RESULT_HI}) ||
                 (wIndex == {1'b0, `RA_RESULT_LO});

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      awHeld <= 1'b0;
      awAddr <= 12'h000;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      awHeld <= 1'b0;
    end else begin
      s_axi_awready <= !awHeld;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wHeld <= 1'b0;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      wHeld <= 1'b0;
    end else begin
      s_axi_wready <= !wHeld;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (writeFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wMapped ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // =========================================
  // Start selection
  wire busy = (state != ST_IDLE);
  wire pinRise = pinSync && !pinPrev;
  wire t2Ovf = t2Wide ? timerOvf.t2High : timerOvf.t2Low;
  wire t3Ovf = t3Wide ? timerOvf.t3High : timerOvf.t3Low;
  wire swStart = wrControl && wByte[`CTL_BUSY];
  wire selectedStart = (startSource == SRC_SOFTWARE) ? swStart :
                       (startSource == SRC_TIMER0) ? timerOvf.t0 :
                       (startSource == SRC_TIMER1) ? timerOvf.t1 :
                       (startSource == SRC_TIMER2) ? t2Ovf :
                       (startSource == SRC_TIMER3) ? t3Ovf :
                       (startSource == SRC_PIN) ? pinRise : 1'b0;
  wire startOk = enable && !busy && (rateCount == 6'h00);
  wire startEvent = selectedStart && startOk;
  wire startDropped = selectedStart && enable && !startOk;
  wire pinLowPower = lowPowerTrack && (startSource == SRC_PIN);
  wire sarTick;
  wire lastTrack = (state == ST_TRACK) && sarTick &&
                   (phaseCount == 4'(`TRACK_SAR_CLKS - 1));
  wire lastConvert = (state == ST_CONVERT) && sarTick &&
                     (phaseCount == 4'(`CONV_SAR_CLKS - 1));
  wire differential = (negChannel != `NEG_GROUND);
  wire trackNow = enable && !standby &&
                  (lowPowerTrack ? ((state == ST_TRACK) ||
                                    (pinLowPower && !busy && !pinSync))
                                 : (state != ST_CONVERT));

  sar_clock_divider sar_clock_divider_inst (
    .clk(ref_clk),
    .rstn(rstn),
    .run(busy && enable),
    .divisor(divisor),
    .tick(sarTick)
  );

  // =========================================
  // Conversion sequencer
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      phaseCount <= 4'h0;
    end else if (!enable) begin
      state <= ST_IDLE;
      phaseCount <= 4'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          phaseCount <= 4'h0;
          if (startEvent) begin
            state <= (lowPowerTrack && !pinLowPower) ? ST_TRACK : ST_CONVERT;
          end
        end
        ST_TRACK: begin
          if (lastTrack) begin
            state <= ST_CONVERT;
            phaseCount <= 4'h0;
          end else if (sarTick) begin
            phaseCount <= phaseCount + 4'h1;
          end
        end
        ST_CONVERT: begin
          if (lastConvert) begin
            state <= ST_IDLE;
            phaseCount <= 4'h0;
          end else if (sarTick) begin
            phaseCount <= phaseCount + 4'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
          phaseCount <= 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rateCount <= 6'h00;
    end else if (startEvent) begin
      rateCount <= 6'(`MIN_SAMPLE_CYCLES - 1);
    end else if (rateCount != 6'h00) begin
      rateCount <= rateCount - 6'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      result <= 16'h0000;
      completePulse <= 1'b0;
    end else begin
      completePulse <= lastConvert && enable; // Marks the busy falling edge
      if (lastConvert) begin
        result <= formatResult(sarCode, leftJustify, differential);
      end
    end
  end

  // =========================================
  // Software registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      enable <= 1'(`CONTROL_RESET >> `CTL_ENABLE);
      lowPowerTrack <= 1'b0;
      startSource <= 3'h0;
      leftJustify <= 1'b0;
      divisor <= 5'(`CONFIG_RESET >> `CFG_DIV_LSB);
      posChannel <= `POS_SEL_RESET;
      negChannel <= `NEG_SEL_RESET;
      {t2Wide, t3Wide, standby} <= `TIMER_MODE_RESET;
      irqMask <= 2'b00;
    end else begin
      if (wrControl) begin
        enable <= wByte[`CTL_ENABLE];
        lowPowerTrack <= wByte[`CTL_LPTRACK];
        startSource <= wByte[`CTL_SRC_MSB:`CTL_SRC_LSB];
        leftJustify <= wByte[`CTL_LJUST];
      end
      if (wrConfig) begin
        divisor <= wByte[`CFG_DIV_MSB:`CFG_DIV_LSB];
      end
      if (wrPos) begin
        posChannel <= wByte[4:0];
      end
      if (wrNeg) begin
        negChannel <= wByte[4:0];
      end
      if (wrTimerMode) begin
        t2Wide <= wByte[`TM_T2_WIDE];
        t3Wide <= wByte[`TM_T3_WIDE];
        standby <= wByte[`TM_STANDBY];
      end
      if (wrMask) begin
        irqMask <= wByte[1:0];
      end
    end
  end

  // Sticky event flags: a set in the same cycle as a clear wins
  wire clearDone = (wrControl && !wByte[`CTL_DONE]) || (wrStatus && wByte[`IRQ_DONE]);
  wire clearDropped = wrStatus && wByte[`IRQ_DROPPED];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      doneFlag <= 1'b0;
      droppedFlag <= 1'b0;
    end else begin
      doneFlag <= completePulse || (doneFlag && !clearDone);
      droppedFlag <= startDropped || (droppedFlag && !clearDropped);
    end
  end

  // =========================================
  // Read channel
  logic [7:0] readByte;
  logic readMapped;
  wire [8:0] rIndex = regIndex(s_axi_araddr);

  always_comb begin
    readByte = 8'h00;
    readMapped = 1'b1;
    if (rIndex == {1'b0, `RA_CONTROL}) begin
      readByte = {enable, lowPowerTrack, doneFlag, busy, startSource, leftJustify};
    end else if (rIndex == {1'b0, `RA_CONFIG}) begin
      readByte = {divisor, 3'h0};
    end else if (rIndex == {1'b0, `RA_POS_SEL}) begin
      readByte = {3'h0, posChannel};
    end else if (rIndex == {1'b0, `RA_NEG_SEL}) begin
      readByte = {3'h0, negChannel};
    end else if (rIndex == {1'b0, `RA_RESULT_HI}) begin
      readByte = result[15:8];
    end else if (rIndex == {1'b0, `RA_RESULT_LO}) begin
      readByte = result[7:0];
    end else if (rIndex == {1'b0, `RA_IRQ_STATUS}) begin
      readByte = {6'h00, droppedFlag, doneFlag};
    end else if (rIndex == {1'b0, `RA_IRQ_MASK}) begin
      readByte = {6'h00, irqMask};
    end else if (rIndex == {1'b0, `RA_TIMER_MODE}) begin
      readByte = {5'h00, standby, t3Wide, t2Wide};
    end else begin
      readMapped = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, readByte};
      s_axi_rresp <= readMapped ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid;
    end
  end

  // =========================================
  // Outputs
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      analogCtl <= '0;
      irq <= 1'b0;
    end else begin
      analogCtl.powered <= enable;
      analogCtl.track <= trackNow;
      analogCtl.convert <= (state == ST_CONVERT) && enable;
      analogCtl.sarTick <= sarTick;
      analogCtl.differential <= differential;
      analogCtl.posChannel <= posChannel;
      analogCtl.negChannel <= negChannel;
      irq <= (doneFlag && irqMask[`IRQ_DONE]) || (droppedFlag && irqMask[`IRQ_DROPPED]);
    end
  end

endmodule : sar_adc_conversion_control

// ### sar_adc_conversion_control_sva.sv
`timescale 1ns/1ps
module sar_adc_conversion_control_sva
  import sar_adc_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic s_axi_awvalid, // AW valid
  input wire logic s_axi_awready, // AW ready
  input wire logic s_axi_wvalid, // W valid
  input wire logic s_axi_wready, // W ready
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_bready, // B ready
  input wire logic s_axi_arvalid, // AR valid
  input wire logic s_axi_arready, // AR ready
  input wire logic s_axi_rvalid, // R valid
  input wire analog_ctl_type analogCtl, // Analog controls
  input wire logic irq // Interrupt
);
  // ====
  // Helper: cycles since the last conversion began
  logic [5:0] gap;
  logic convPrev;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap <= 6'h3f;
      convPrev <= 1'b0;
    end else begin
      convPrev <= analogCtl.convert;
      if (analogCtl.convert && !convPrev) begin
        gap <= 6'h00;
      end else if (gap != 6'h3f) begin
        gap <= gap + 6'h01;
      end
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wrAnswer;
    ##[1:3] s_axi_bvalid;
  endsequence
  a_wr_answer: assert property (wrTaken |-> wrAnswer)
    else $error("write not answered");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid)
    else $error("read not answered");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during response");
  a_track_idle: assert property (analogCtl.convert |-> !analogCtl.track)
    else $error("tracking during conversion");
  a_off_quiet: assert property (!analogCtl.powered |-> !analogCtl.convert && !analogCtl.sarTick)
    else $error("converter active while off");
  a_conv_hold: assert property ($rose(analogCtl.convert) |-> analogCtl.convert [*8])
    else $error("conversion cut short");
  a_no_restart: assert property ($rose(analogCtl.convert) |-> gap >= 6'd12)
    else $error("conversion restarted");
  a_irq_clear: assert property ($fell(irq) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("interrupt fell without a write");
endmodule : sar_adc_conversion_control_sva
bind sar_adc_conversion_control sar_adc_conversion_control_sva sva_inst (.ref_clk(ref_clk),
  .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .analogCtl(analogCtl), .irq(irq));

// ### sar_adc_conversion_control_tb_top.sv
`timescale 1ns/1ps
`include "sar_adc_regs.svh"
module sar_adc_conversion_control_tb_top import sar_adc_pkg::*; ();
  logic clk = 1'b0;
  logic rstN = 1'b0;
  logic [11:0] awAddr = 12'h000;
  logic [11:0] arAddr = 12'h000;
  logic [31:0] wData = 32'h0;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid, irq, pin;
  logic pinLevel = 1'b0;
  logic [1:0] bResp, rResp, resp;
  logic [31:0] rData, rdv;
  logic [11:0] code = 12'h000;
  logic [11:0] sarCode;
  timer_strobe_type fire = '0;
  timer_strobe_type ovf;
  analog_ctl_type actl;
  logic [15:0] expQ [$];
  int nFail = 0, cmpCount = 0, nConv = 0, nTrack = 0, seed = 32'h00d86832, nTick = 0;
  logic [7:0] regIdx [7] = '{`RA_CONTROL, `RA_CONFIG, `RA_POS_SEL, `RA_NEG_SEL,
    `RA_IRQ_MASK, `RA_IRQ_STATUS, `RA_TIMER_MODE};
  logic [7:0] regRst [7] = '{8'h00, 8'hf8, 8'h00, 8'h1f, 8'h00, 8'h00, 8'h00};
  always #50 clk = ~clk;
  always @(posedge clk) begin
    if (actl.convert) nConv++;
    if (actl.track) nTrack++;
    if (actl.sarTick) nTick++;
  end
  sar_adc_conversion_control sar_adc_conversion_control_inst (.ref_clk(clk), .rst_n(rstN),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'h1), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .timerOvf(ovf), .convertStartPin(pin), .sarCode(sarCode), .analogCtl(actl), .irq(irq));
  sar_start_partner sar_start_partner_inst (.clk(clk), .fire(fire), .pinLevel(pinLevel),
    .code(code), .convert(actl.convert), .timerOvf(ovf), .convertStartPin(pin),
    .sarCode(sarCode));
  // ====
  // Bus cycles and comparison
  task automatic check(input string what, input logic [31:0] seen, exp);
    cmpCount++;
    if (seen !== exp) begin
      nFail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    logic aHs, wHs, bHs;
    @(posedge clk);
    awAddr <= {2'b00, idx, 2'b00};
    wData <= {24'h0, val};
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    bHs = 1'b0;
    while (!bHs) begin
      @(negedge clk);
      aHs = awValid && awReady;
      wHs = wValid && wReady;
      bHs = bValid;
      resp = bResp;
      @(posedge clk);
      if (aHs) awValid <= 1'b0;
      if (wHs) wValid <= 1'b0;
    end
    bReady <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] idx);
    logic aHs, hs;
    @(posedge clk);
    arAddr <= {2'b00, idx, 2'b00};
    arValid <= 1'b1;
    rReady <= 1'b1;
    hs = 1'b0;
    while (!hs) begin
      @(negedge clk);
      aHs = arValid && arReady;
      hs = rValid;
      rdv = rData;
      resp = rResp;
      @(posedge clk);
      if (aHs) arValid <= 1'b0;
    end
    rReady <= 1'b0;
  endtask : rd
  task automatic kick(input int k);
    @(posedge clk);
    if (k == 6) pinLevel <= 1'b1;
    else fire <= timer_strobe_type'(6'h01 << k);
    @(posedge clk);
    fire <= '0;
  endtask : kick
  task automatic closeOut();
    if (nFail == 0 && cmpCount > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : closeOut
  // ====
  // One conversion against the expected result
  task automatic conv(input logic [2:0] src, input logic lj, lp, diff, input logic [4:0] div,
      input logic [2:0] tm, input int k, ig, input logic msk, again);
    logic [4:0] pos;
    logic [11:0] c;
    logic [7:0] ctl, hi;
    int i;
    repeat (50) @(posedge clk);
    pos = 5'($random(seed));
    c = 12'($random(seed));
    ctl = {1'b1, lp, 2'b00, src, lj};
    code <= c;
    expQ.push_back(lj ? {c, 4'h0} : {{4{diff & c[11]}}, c});
    wr(`RA_CONFIG, {div, 3'b000});
    wr(`RA_NEG_SEL, diff ? 8'h00 : 8'h1f);
    wr(`RA_POS_SEL, {3'b111, pos});
    wr(`RA_TIMER_MODE, {5'h00, tm});
    wr(`RA_IRQ_MASK, {7'h00, msk});
    wr(`RA_CONTROL, ctl);
    rd(`RA_POS_SEL);
    check("pos", rdv, {27'h0, pos});
    @(negedge clk);
    check("chan", {actl.differential, actl.posChannel}, {diff, pos});
    check("neg", actl.negChannel, {5{!diff}});
    if (ig < 8) begin
      kick(ig);
      repeat (6) @(posedge clk);
      rd(`RA_CONTROL);
      check("ignored", rdv[5:4], 2'b00);
    end
    @(negedge clk);
    nConv = 0;
    nTrack = 0;
    nTick = 0;
    if (k == 7) wr(`RA_CONTROL, ctl | 8'h10);
    else kick(k);
    repeat (4) @(posedge clk);
    rd(`RA_CONTROL);
    check("busy", rdv[5:4], 2'b01);
    for (i = 0; i < 300 && !rdv[5]; i++) rd(`RA_CONTROL);
    check("done", rdv[5:4], 2'b10);
    if (again) begin
      // Done bit written as one so this start does not clear the flag
      wr(`RA_CONTROL, ctl | 8'h30);
      rd(`RA_IRQ_STATUS);
      check("dropped", rdv[1:0], 2'b11);
    end
    rd(`RA_RESULT_HI);
    hi = rdv[7:0];
    rd(`RA_RESULT_LO);
    check("result", {hi, rdv[7:0]}, expQ.pop_front());
    @(negedge clk);
    check("irq", irq, msk);
    check("conv clocks", nConv, 13 * (div + 1));
    check("sar ticks", nTick, (lp && k != 6) ? 16 : 13);
    if (lp && k != 6) check("track clocks", nTrack, 3 * (div + 1));
    if (k != 6) check("idle track", actl.track, !lp);
    wr(`RA_IRQ_STATUS, 8'h03);
    wr(`RA_CONTROL, ctl);
    pinLevel <= 1'b0;
    @(negedge clk);
    check("irq clear", irq, 1'b0);
  endtask : conv
  // ====
  // Main sequence
  initial begin
    repeat (40000) @(posedge clk);
    nFail++;
    closeOut();
  end
  initial begin
    logic [31:0] r;
    repeat (12) @(posedge clk);
    rstN <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (regIdx[i]) begin
      rd(regIdx[i]);
      check("reset value", rdv, {24'h0, regRst[i]});
    end
    rd(8'h10);
    check("unmapped data", rdv, 32'h0);
    check("unmapped read", resp, 2'b10);
    wr(8'h10, 8'hff);
    check("unmapped write", resp, 2'b10);
    wr(`RA_CONTROL, 8'h10);
    repeat (20) @(posedge clk);
    rd(`RA_CONTROL);
    @(negedge clk);
    check("off", {actl.powered, rdv[5:4]}, 3'b000);
    wr(`RA_CONTROL, 8'h80);
    @(negedge clk);
    check("on", {actl.powered, actl.track}, 2'b11);
    wr(`RA_TIMER_MODE, 8'h04);
    @(negedge clk);
    check("standby", actl.track, 1'b0);
    conv(SRC_SOFTWARE, 0, 0, 0, 1, 0, 7, 5, 1, 0);
    conv(SRC_SOFTWARE, 0, 0, 0, 0, 0, 7, 8, 1, 1);
    conv(SRC_TIMER0, 1, 0, 0, 0, 0, 5, 4, 1, 0);
    conv(SRC_TIMER1, 0, 1, 1, 2, 0, 4, 5, 0, 0);
    conv(SRC_TIMER2, 0, 0, 0, 1, 0, 3, 2, 1, 0);
    conv(SRC_TIMER2, 1, 1, 1, 3, 1, 2, 3, 1, 0);
    conv(SRC_TIMER3, 0, 0, 1, 1, 0, 1, 0, 1, 0);
    conv(SRC_TIMER3, 1, 0, 0, 2, 2, 0, 1, 1, 0);
    conv(SRC_PIN, 0, 1, 0, 1, 0, 6, 5, 1, 0);
    conv(SRC_PIN, 1, 0, 1, 0, 0, 6, 8, 0, 0);
    repeat (3) begin
      r = $random(seed);
      conv(SRC_SOFTWARE, r[0], r[1], r[2], r[7:3], 3'h0, 7, 8, r[8], 0);
    end
    @(posedge clk);
    rstN <= 1'b0;
    repeat (2) @(posedge clk);
    rstN <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`RA_POS_SEL);
    check("pos after reset", rdv, 32'h0);
    closeOut();
  end
endmodule : sar_adc_conversion_control_tb_top

// ### sar_adc_pkg.sv
package sar_adc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TRACK = 2'b01,
    ST_CONVERT = 2'b10
  } conv_state_type;

  typedef enum logic [2:0] {
    SRC_SOFTWARE = 3'b000,
    SRC_TIMER0 = 3'b001,
    SRC_TIMER2 = 3'b010,
    SRC_TIMER1 = 3'b011,
    SRC_PIN = 3'b100,
    SRC_TIMER3 = 3'b101
  } start_src_type;

  typedef struct packed {
    logic t0;
    logic t1;
    logic t2Low;
    logic t2High;
    logic t3Low;
    logic t3High;
  } timer_strobe_type;

  typedef struct packed {
    logic powered;
    logic track;
    logic convert;
    logic sarTick;
    logic differential;
    logic [4:0] posChannel;
    logic [4:0] negChannel;
  } analog_ctl_type;

endpackage : sar_adc_pkg

// ### sar_adc_regs.svh
// Function
// - Converter clock is system clock divided by divisor field plus one, divisor 0..31.
// - Conversions never start faster than 200 ksps, whatever source or divisor.
// - Start-source field picks software busy write, timer 0/1/2/3 overflow, or pin edge.
// - Busy bit stays one for the whole conversion and clears when it completes.
// - Busy falling edge sets done flag and raises interrupt when enabled.
// - Result registers hold the new result before the done flag reads one.
// - Timers 2 and 3 use low-byte overflow in 8-bit mode, high-byte in 16-bit.
// - Default tracking mode tracks the input except during conversion.
// - Low-power tracking inserts 3 converter clocks of tracking after each start other than a pin start.
// - Low-power mode with pin start tracks while pin low, converts on rising edge.
// - Tracking may be shut down in standby or sleep.
// - Positive select register holds 5-bit field; upper three bits read zero.
// - Positive codes pick pins in order, 11110 temperature sensor, 11111 supply.
// - Converter runs only while enable bit is one, else low-power shutdown.
// - Ground negative input means unsigned single-ended, otherwise signed differential.
// - Result is right- or left-justified per control register bit 0.
`ifndef SAR_ADC_REGS_SVH
`define SAR_ADC_REGS_SVH

// Register indices; byte address is four times the index
`define RA_NEG_SEL 8'hba
`define RA_POS_SEL 8'hbb
`define RA_CONFIG 8'hbc
`define RA_CONTROL 8'hc0
`define RA_RESULT_HI 8'hc1
`define RA_RESULT_LO 8'hc2
`define RA_IRQ_STATUS 8'hc3
`define RA_IRQ_MASK 8'hc4
`define RA_TIMER_MODE 8'hc5

// Reset values
`define CONTROL_RESET 8'h00
`define CONFIG_RESET 8'hf8
`define POS_SEL_RESET 5'h00
`define NEG_SEL_RESET 5'h1f
`define TIMER_MODE_RESET 3'h0

// Control fields
`define CTL_ENABLE 7
`define CTL_LPTRACK 6
`define CTL_DONE 5
`define CTL_BUSY 4
`define CTL_SRC_MSB 3
`define CTL_SRC_LSB 1
`define CTL_LJUST 0
// Config fields
`define CFG_DIV_MSB 7
`define CFG_DIV_LSB 3
// Timer mode / power fields
`define TM_T2_WIDE 0
`define TM_T3_WIDE 1
`define TM_STANDBY 2
// Interrupt status bits
`define IRQ_DONE 0
`define IRQ_DROPPED 1

// Input codes
`define NEG_GROUND 5'h1f
`define POS_TEMP 5'h1e
`define POS_SUPPLY 5'h1f

// Timing
`define CLK_PERIOD_NS 100
`define MIN_SAMPLE_NS 5000
`define MIN_SAMPLE_CYCLES ((`MIN_SAMPLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TRACK_SAR_CLKS 3
`define CONV_SAR_CLKS 13

`endif

// ### sar_clock_divider.sv
`timescale 1ns/1ps
module sar_clock_divider (
  input wire logic clk,             // System clock
  input wire logic rstn,            // Synchronised reset, active low
  input wire logic run,             // Count while high, restart when low
  input wire logic [4:0] divisor,   // Divide by divisor plus one
  output logic tick                 // One-cycle converter clock enable
);

  logic [4:0] count;

  assign tick = run && (count == divisor);

  // =========================================
  // Divider counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= 5'h00;
    end else if (!run || tick) begin
      count <= 5'h00;
    end else begin
      count <= count + 5'h01;
    end
  end

endmodule : sar_clock_divider

// ### sar_start_partner.sv
`timescale 1ns/1ps
module sar_start_partner
  import sar_adc_pkg::*;
(
  input wire logic clk, // System clock
  input wire timer_strobe_type fire, // Strobes asked for
  input wire logic pinLevel, // Pin level asked for
  input wire logic [11:0] code, // Code of the next conversion
  input wire logic convert, // Converter converting
  output timer_strobe_type timerOvf, // Overflow strobes
  output logic convertStartPin, // Start pin
  output logic [11:0] sarCode // Array code
);
  always_ff @(posedge clk) begin
    timerOvf <= fire;
    convertStartPin <= pinLevel;
  end
  // Outside a conversion the array shows the inverted code
  assign sarCode = convert ? code : ~code;
endmodule : sar_start_partner
